// >>> shared/acq_consts.svh
// What this block does
// - surface format still sends acquisition squitters
// - surface squitters stopped: start acquisition squitters
// - acquisition squitters go at one per second
// - surface state with diversity sends acquisition squitters on top antenna only
// - not inhibited: airborne/unknown always, surface conditionally
// - inhibited: only while no surveillance squitter
// - no data, or lockout in surface format, means no extended squitter
// - own vertical status into capability field
// - format commands never touch status fields
// - surveillance types: airborne position, velocity, surface
// - capability shows ground, flight status, downlink waiting
`ifndef ACQ_CONSTS_SVH
`define ACQ_CONSTS_SVH

// register byte offsets
`define REG_CTRL_OFS        8'h00
`define REG_AIRCRAFT_OFS    8'h04
`define REG_ES_ENABLE_OFS   8'h08
`define REG_STATUS_OFS      8'h0C
`define REG_ACQ_COUNT_OFS   8'h10
`define REG_ES_COUNT_OFS    8'h14

// control register fields
`define CTRL_INHIBIT_BIT    0
`define CTRL_FMT_LSB        1
`define CTRL_FMT_MSB        2
`define CTRL_LOCKOUT_BIT    3
`define CTRL_DIVERSITY_BIT  4
`define CTRL_WIDTH          5
`define CTRL_RESET          5'h00

// aircraft register fields
`define AC_AUTO_DETECT_BIT  0
`define AC_COND_LSB         1
`define AC_COND_MSB         2
`define AC_DATA_VALID_BIT   3
`define AC_FS_ALERT_BIT     4
`define AC_DR_WAITING_BIT   5
`define AC_WIDTH            6
`define AC_RESET            6'h00

// squitter type enable fields
`define ES_AIR_POS_BIT      0
`define ES_AIR_VEL_BIT      1
`define ES_SURF_POS_BIT     2
`define ES_IDENT_BIT        3
`define ES_EN_WIDTH         4
`define ES_EN_RESET         4'hF

// status register fields
`define ST_ELIGIBLE_BIT     0
`define ST_SURV_BIT         1
`define ST_REP_SURF_BIT     2
`define ST_SURF_STATE_BIT   3
`define ST_CA_LSB           4
`define ST_VS_BIT           7
`define ST_FS_LSB           8

// capability field codes
`define CA_ON_GROUND        3'h4
`define CA_AIRBORNE         3'h5
`define CA_EITHER           3'h6
`define CA_ALERT_OR_DR      3'h7

// flight status field codes
`define FS_AIR_NO_ALERT     3'h0
`define FS_GND_NO_ALERT     3'h1
`define FS_AIR_ALERT        3'h2
`define FS_GND_ALERT        3'h3
`define FS_EITHER_ALERT     3'h4

// timing
`define CLK_FREQ_HZ         50000000
`define ACQ_PERIOD_MS       1000
`define ES_PERIOD_MS        500
`define ACQ_PERIOD_CYC      (`CLK_FREQ_HZ / 1000 * `ACQ_PERIOD_MS)
`define ES_PERIOD_CYC       (`CLK_FREQ_HZ / 1000 * `ES_PERIOD_MS)

`endif

// >>> shared/acq_pkg.sv
package acq_pkg;

    // on-ground condition as the aircraft determines it
    typedef enum logic [1:0] {
        COND_AIRBORNE = 2'h0,
        COND_SURFACE  = 2'h1,
        COND_UNKNOWN  = 2'h2
    } ground_cond_e;

    // position_format_command values
    typedef enum logic [1:0] {
        FMT_NONE    = 2'h0,
        FMT_AIR     = 2'h1,
        FMT_SURFACE = 2'h2
    } fmt_cmd_e;

    // apb request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    // apb answer to the master
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_s;

    // squitter scheduling outputs
    typedef struct packed {
        logic       acq_req;
        logic       es_req;
        logic       es_surface;
        logic       ant_top;
        logic       ant_bottom;
        logic [2:0] capability_field;
        logic [2:0] flight_status_field;
        logic       vertical_status_field;
    } sq_out_s;

endpackage : acq_pkg

// >>> logic/acq_rate_timer.sv
`timescale 1ns/1ns
// free-running period counter, one tick pulse per period
module acq_rate_timer
    import acq_pkg::*;
#(
    parameter int unsigned PERIOD = 1000,
    parameter int unsigned CW     = $clog2(PERIOD + 1)
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // restart counting from zero
    input  wire logic restart,
    // one cycle at the end of each period
    output logic      tick
);

    // all state of the timer
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          tick;
    } timer_state_s;

    timer_state_s s_q;   // registered state
    timer_state_s s_d;   // next state

    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    // next count and tick
    always_comb begin
        s_d      = s_q;
        s_d.tick = 1'b0;
        if (restart) begin
            s_d.cnt = '0;
        end else if (s_q.cnt == LAST) begin
            // wrap and announce the period end
            s_d.cnt  = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + CW'(1);
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

endmodule : acq_rate_timer

// >>> logic/acq_squitter_ctrl.sv
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ns
`include "acq_consts.svh"
// acquisition squitter scheduling and antenna choice, apb controlled
module acq_squitter_ctrl
    import acq_pkg::*;
#(
    parameter int unsigned ACQ_PERIOD = `ACQ_PERIOD_CYC,
    parameter int unsigned ES_PERIOD  = `ES_PERIOD_CYC,
    parameter int unsigned CNT_W      = 16
) (
    // clock and reset
    input  wire logic     pclk,
    input  wire logic     presetn,
    // register bus
    input  wire apb_req_s apb_req,
    output apb_rsp_s      apb_rsp,
    // squitter scheduling
    output sq_out_s       sq_out
);

    // all state of the block
    typedef struct packed {
        logic [`CTRL_WIDTH-1:0]   ctrl;       // inhibit, format, lockout, diversity
        logic [`AC_WIDTH-1:0]     aircraft;   // own determinations
        logic [`ES_EN_WIDTH-1:0]  es_en;      // squitter types fitted
        logic                     eligible;   // last evaluated eligibility
        logic                     surv;       // surveillance squitter active
        logic                     rep_surf;   // surface format reported
        logic                     surf_state; // block in surface state
        logic                     ant_toggle; // diversity alternation
        logic [CNT_W-1:0]         acq_cnt;    // acquisition squitters sent
        logic [CNT_W-1:0]         es_cnt;     // extended squitters sent
        apb_rsp_s                 rsp;        // bus answer
        sq_out_s                  out;        // scheduling outputs
    } ctrl_state_s;

    ctrl_state_s s_q;    // registered state
    ctrl_state_s s_d;    // next state

    logic acq_tick;      // acquisition scheduling opportunity
    logic es_tick;       // extended squitter opportunity
    logic acq_restart;   // realign acquisition period

    // decoded fields of the persistent flags
    logic         inhibit;
    fmt_cmd_e     fmt_cmd;
    logic         lockout;
    logic         diversity;
    logic         auto_detect;
    ground_cond_e own_cond;
    ground_cond_e cond;
    logic         data_valid;
    logic         fs_alert;
    logic         dr_waiting;

    // combinational evaluation
    logic         rep_surf;
    logic         no_es;
    logic         surv;
    logic         eligible;
    logic         surf_state;
    logic [2:0]   ca_val;
    logic [2:0]   fs_val;
    logic         vs_val;
    logic         was_surface_es;

    // apb phase decode
    logic         access;
    logic         do_write;
    logic         do_read;
    logic         mapped;

    // map a byte address to a register hit, unaligned is unmapped
    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
        is_reg = (a == ofs);
    endfunction : is_reg

    // true for every address with a register behind it
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = is_reg(a, `REG_CTRL_OFS)      || is_reg(a, `REG_AIRCRAFT_OFS)
                   || is_reg(a, `REG_ES_ENABLE_OFS) || is_reg(a, `REG_STATUS_OFS)
                   || is_reg(a, `REG_ACQ_COUNT_OFS) || is_reg(a, `REG_ES_COUNT_OFS);
    endfunction : addr_mapped

    // acquisition squitter period, one per second
    acq_rate_timer #(
        .PERIOD (ACQ_PERIOD),
        .CW     ($clog2(ACQ_PERIOD + 1))
    ) u_acq_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (acq_restart),
        .tick    (acq_tick)
    );

    // extended squitter period, two per second
    acq_rate_timer #(
        .PERIOD (ES_PERIOD),
        .CW     ($clog2(ES_PERIOD + 1))
    ) u_es_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (1'b0),
        .tick    (es_tick)
    );

    // field extraction from the held flags
    always_comb begin
        inhibit     = s_q.ctrl[`CTRL_INHIBIT_BIT];
        fmt_cmd     = fmt_cmd_e'(s_q.ctrl[`CTRL_FMT_MSB:`CTRL_FMT_LSB]);
        lockout     = s_q.ctrl[`CTRL_LOCKOUT_BIT];
        diversity   = s_q.ctrl[`CTRL_DIVERSITY_BIT];
        auto_detect = s_q.aircraft[`AC_AUTO_DETECT_BIT];
        own_cond    = ground_cond_e'(s_q.aircraft[`AC_COND_MSB:`AC_COND_LSB]);
        data_valid  = s_q.aircraft[`AC_DATA_VALID_BIT];
        fs_alert    = s_q.aircraft[`AC_FS_ALERT_BIT];
        dr_waiting  = s_q.aircraft[`AC_DR_WAITING_BIT];
        // without automatic detection the condition is unknown
        cond        = auto_detect ? own_cond : COND_UNKNOWN;
        // illegal code 3 counts as unknown
        if (cond != COND_AIRBORNE && cond != COND_SURFACE) begin
            cond = COND_UNKNOWN;
        end
    end

    // squitter eligibility and reported fields
    always_comb begin
        // format command picks the position format, else own condition
        unique case (fmt_cmd)
            FMT_AIR:     rep_surf = 1'b0;
            FMT_SURFACE: rep_surf = 1'b1;
            default:     rep_surf = (cond == COND_SURFACE);
        endcase
        no_es = !data_valid || (lockout && rep_surf);
        if (no_es) begin
            surv = 1'b0;
        end else if (rep_surf) begin
            surv = s_q.es_en[`ES_SURF_POS_BIT];
        end else begin
            surv = s_q.es_en[`ES_AIR_POS_BIT] || s_q.es_en[`ES_AIR_VEL_BIT];
        end
        if (!inhibit) begin
            eligible = (cond != COND_SURFACE) || !surv;
        end else begin
            eligible = !surv && !(rep_surf && !no_es);
        end
        // surface state: reporting surface or determined surface
        surf_state = rep_surf || (cond == COND_SURFACE);
        // fields below read own determination, never fmt_cmd
        if (fs_alert || dr_waiting) begin
            ca_val = `CA_ALERT_OR_DR;
        end else begin
            unique case (cond)
                COND_AIRBORNE: ca_val = `CA_AIRBORNE;
                COND_SURFACE:  ca_val = `CA_ON_GROUND;
                default:       ca_val = `CA_EITHER;
            endcase
        end
        // flight status from condition and alert
        unique case (cond)
            COND_AIRBORNE: fs_val = fs_alert ? `FS_AIR_ALERT : `FS_AIR_NO_ALERT;
            COND_SURFACE:  fs_val = fs_alert ? `FS_GND_ALERT : `FS_GND_NO_ALERT;
            default:       fs_val = fs_alert ? `FS_EITHER_ALERT : `FS_AIR_NO_ALERT;
        endcase
        vs_val = (cond == COND_SURFACE);
        // surface squitters were running and have just stopped
        was_surface_es = s_q.surv && s_q.rep_surf && !(surv && rep_surf);
    end

    // stop of surface squitters starts acquisition at once
    assign acq_restart = was_surface_es && eligible;

    // apb phases: first access cycle raises pready for the next
    always_comb begin
        access   = apb_req.psel && apb_req.penable && !s_q.rsp.pready;
        mapped   = addr_mapped(apb_req.paddr);
        do_write = access && apb_req.pwrite && mapped;
        do_read  = access && !apb_req.pwrite && mapped;
    end

    // next state of the whole block
    always_comb begin
        s_d = s_q;
        // bus answer defaults to idle
        s_d.rsp.pready  = 1'b0;
        s_d.rsp.pslverr = 1'b0;
        s_d.rsp.prdata  = 32'h0000_0000;
        // pulses last one cycle
        s_d.out.acq_req = 1'b0;
        s_d.out.es_req  = 1'b0;
        // persistent flags change only by write
        if (do_write) begin
            if (is_reg(apb_req.paddr, `REG_CTRL_OFS)) begin
                s_d.ctrl = apb_req.pwdata[`CTRL_WIDTH-1:0];
            end else if (is_reg(apb_req.paddr, `REG_AIRCRAFT_OFS)) begin
                s_d.aircraft = apb_req.pwdata[`AC_WIDTH-1:0];
            end else if (is_reg(apb_req.paddr, `REG_ES_ENABLE_OFS)) begin
                s_d.es_en = apb_req.pwdata[`ES_EN_WIDTH-1:0];
            end else begin
                // status and counters are read only, write ignored
                s_d.ctrl = s_q.ctrl;
            end
        end
        // answer one cycle after the first access cycle
        if (access) begin
            s_d.rsp.pready  = 1'b1;
            s_d.rsp.pslverr = !mapped;
        end
        // read mux, bits above each field read zero
        if (do_read) begin
            if (is_reg(apb_req.paddr, `REG_CTRL_OFS)) begin
                s_d.rsp.prdata = {27'h0, s_q.ctrl};
            end else if (is_reg(apb_req.paddr, `REG_AIRCRAFT_OFS)) begin
                s_d.rsp.prdata = {26'h0, s_q.aircraft};
            end else if (is_reg(apb_req.paddr, `REG_ES_ENABLE_OFS)) begin
                s_d.rsp.prdata = {28'h0, s_q.es_en};
            end else if (is_reg(apb_req.paddr, `REG_STATUS_OFS)) begin
                s_d.rsp.prdata = {21'h0, s_q.out.flight_status_field,
                                  s_q.out.vertical_status_field,
                                  s_q.out.capability_field, s_q.surf_state,
                                  s_q.rep_surf, s_q.surv, s_q.eligible};
            end else if (is_reg(apb_req.paddr, `REG_ACQ_COUNT_OFS)) begin
                s_d.rsp.prdata = 32'(s_q.acq_cnt);
            end else begin
                s_d.rsp.prdata = 32'(s_q.es_cnt);
            end
        end
        // tracked evaluation, shown in status
        s_d.surv       = surv;
        s_d.rep_surf   = rep_surf;
        s_d.surf_state = surf_state;
        s_d.eligible   = eligible;
        // status fields follow own determination continuously
        s_d.out.capability_field      = ca_val;
        s_d.out.flight_status_field   = fs_val;
        s_d.out.vertical_status_field = vs_val;
        if ((acq_tick && eligible) || acq_restart) begin
            s_d.out.acq_req = 1'b1;
            s_d.acq_cnt     = s_q.acq_cnt + CNT_W'(1);
            if (!diversity) begin
                // single antenna installation
                s_d.out.ant_top    = 1'b0;
                s_d.out.ant_bottom = 1'b1;
            end else if (surf_state) begin
                s_d.out.ant_top    = 1'b1;
                s_d.out.ant_bottom = 1'b0;
            end else begin
                // airborne diversity alternates antennas
                s_d.out.ant_top    = !s_q.ant_toggle;
                s_d.out.ant_bottom = s_q.ant_toggle;
                s_d.ant_toggle     = !s_q.ant_toggle;
            end
        end
        // surveillance squitters at two per second when active
        if (es_tick && surv) begin
            s_d.out.es_req = 1'b1;
            s_d.es_cnt     = s_q.es_cnt + CNT_W'(1);
        end
        // format carried with each extended squitter
        s_d.out.es_surface = rep_surf;
    end

    // state register, control and aircraft flags clear at reset, squitter type enables set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q          <= '0;
            s_q.ctrl     <= `CTRL_RESET;
            s_q.aircraft <= `AC_RESET;
            s_q.es_en    <= `ES_EN_RESET;
            s_q.out.ant_bottom <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops
    assign apb_rsp = s_q.rsp;
    assign sq_out  = s_q.out;

endmodule : acq_squitter_ctrl

// >>> verification/acq_squitter_ctrl_sva.sv
`timescale 1ns/1ns
// port checker for the squitter controller
module acq_squitter_ctrl_sva
    import acq_pkg::*;
(
    // clock and reset
    input wire logic     pclk,
    input wire logic     presetn,
    // register bus
    input wire apb_req_s apb_req,
    input wire apb_rsp_s apb_rsp,
    // squitter scheduling
    input wire sq_out_s  sq_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic div_q; // diversity bit as last written
    logic acc;   // access phase on the bus
    assign acc = apb_req.psel && apb_req.penable;

    // shadow of the diversity bit, taken at write completion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 1'b0;
        end else if (acc && apb_rsp.pready && apb_req.pwrite && apb_req.paddr == 8'h00) begin
            div_q <= apb_req.pwdata[4];
        end
    end

    a_one_wait: assert property (acc && !apb_rsp.pready |=> apb_rsp.pready)
        else $error("pready not after one wait state");
    a_rdata_idle: assert property (!apb_rsp.pready |-> apb_rsp.prdata == 32'h0 && !apb_rsp.pslverr)
        else $error("response fields set outside pready");
    a_bad_addr: assert property (acc && apb_rsp.pready
        && (apb_req.paddr > 8'h14 || apb_req.paddr[1:0] != 2'h0) |-> apb_rsp.pslverr)
        else $error("unmapped access without error");
    a_surface_top: assert property (
        sq_out.acq_req && div_q && $past(div_q, 3) && (sq_out.es_surface
        || sq_out.vertical_status_field) |-> sq_out.ant_top) else $error("surface squitter not on top");
    a_ant_exclusive: assert property (sq_out.ant_top != sq_out.ant_bottom)
        else $error("antenna selection not exclusive");
    a_vs_in_ca: assert property (
        sq_out.capability_field == 3'h4 || (sq_out.vertical_status_field
        && sq_out.capability_field != 3'h7) |-> sq_out.vertical_status_field
        && sq_out.capability_field == 3'h4) else $error("capability disagrees with vertical status");
    a_fs_alert_ca: assert property (
        sq_out.flight_status_field inside {3'h2, 3'h3, 3'h4} |-> sq_out.capability_field == 3'h7)
        else $error("alert not shown in capability");
    a_acq_pulse: assert property (sq_out.acq_req |=> !sq_out.acq_req)
        else $error("acquisition request longer than a cycle");
    a_surf_es_quiet: assert property (
        sq_out.es_req && sq_out.vertical_status_field |-> !sq_out.acq_req)
        else $error("acquisition squitter beside surveillance on surface");

    c_top: cover property (sq_out.acq_req && sq_out.ant_top);
    c_es: cover property (sq_out.es_req);
    c_err: cover property (apb_rsp.pready && apb_rsp.pslverr);
endmodule : acq_squitter_ctrl_sva

bind acq_squitter_ctrl acq_squitter_ctrl_sva u_sva (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .sq_out(sq_out));

// >>> verification/sq_listener.sv
`timescale 1ns/1ns
// receivers on the far side: count what they hear
module sq_listener
    import acq_pkg::*;
(
    // clock and reset
    input  wire logic    pclk,
    input  wire logic    presetn,
    // squitters from the transponder
    input  wire sq_out_s sq_out,
    // running totals
    output logic [15:0]  n_acq,
    output logic [15:0]  n_es,
    output logic [15:0]  n_top
);
    // a pulse is heard only in the cycle it stands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n_acq <= 16'h0000;
            n_es  <= 16'h0000;
            n_top <= 16'h0000;
        end else begin
            n_acq <= n_acq + 16'(sq_out.acq_req);
            n_es  <= n_es + 16'(sq_out.es_req);
            n_top <= n_top + 16'(sq_out.acq_req && sq_out.ant_top);
        end
    end
endmodule : sq_listener

// >>> verification/tb_acq_squitter_ctrl.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin errors++; \
    $display("FAIL %s exp %0h got %0h", nm, ex, got); end end
module tb_acq_squitter_ctrl;
    import acq_pkg::*;
    localparam int AP = 20; // shortened acquisition period
    localparam int EP = 10; // shortened surveillance period
    logic        pclk, presetn;
    apb_req_s    apb_req;
    apb_rsp_s    apb_rsp;
    sq_out_s     sq_out;
    logic [15:0] n_acq, n_es, n_top, a0, e0, t0;
    logic [31:0] seed, rd;
    logic        err;
    int          errors, n_tests;

    acq_squitter_ctrl #(.ACQ_PERIOD(AP), .ES_PERIOD(EP), .CNT_W(16)) dut (
        .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .sq_out(sq_out));
    sq_listener far (.pclk(pclk), .presetn(presetn), .sq_out(sq_out),
        .n_acq(n_acq), .n_es(n_es), .n_top(n_top));

    // free-running bus clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    // expected status word from control, aircraft and enables
    function automatic logic [10:0] exp_st(input logic [4:0] c, input logic [5:0] a,
                                           input logic [3:0] e);
        logic [1:0] cd;
        logic       rs, sv, el;
        logic [2:0] ca;
        cd = (!a[0] || a[2:1] > 2'h1) ? 2'h2 : a[2:1];
        rs = c[2:1] == 2'h2 || (c[2:1] != 2'h1 && cd == 2'h1);
        sv = a[3] && !(c[3] && rs) && (rs ? e[2] : (e[0] || e[1]));
        el = c[0] ? !sv : (cd != 2'h1 || !sv);
        ca = (a[4] || a[5]) ? 3'h7 : (cd == 2'h1 ? 3'h4 : (cd == 2'h0 ? 3'h5 : 3'h6));
        return {a[4] && cd == 2'h2, a[4] && cd != 2'h2, cd == 2'h1, cd == 2'h1, ca,
                rs || cd == 2'h1, rs, sv, el};
    endfunction : exp_st

    task automatic summarize();
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize

    // one transfer: setup, access until pready, then release
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: ad, pwdata: wd};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (apb_rsp.pready !== 1'b1 && k < 8);
        if (k >= 8) begin
            errors++;
            summarize();
        end
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
    endtask : apb

    // random settings: status, fields and squitter activity
    task automatic rand_case();
        logic [10:0] x;
        seed = xs(seed);
        apb(1'b1, 8'h00, {27'h0, seed[4:0]});
        apb(1'b1, 8'h04, {26'h0, seed[10:5]});
        apb(1'b1, 8'h08, {28'h0, seed[14:11]});
        apb(1'b0, 8'h0C, 32'h0);
        x = exp_st(seed[4:0], seed[10:5], seed[14:11]);
        `CHK("status", {21'h0, x}, rd)
        `CHK("ca", x[6:4], sq_out.capability_field)
        `CHK("vs", x[7], sq_out.vertical_status_field)
        `CHK("fs", x[10:8], sq_out.flight_status_field)
        {a0, e0, t0} = {n_acq, n_es, n_top};
        repeat (2 * AP + 4) @(posedge pclk);
        `CHK("acq", x[0], n_acq != a0)
        `CHK("es", x[1], n_es != e0)
        if (!seed[4]) `CHK("top", t0, n_top)
    endtask : rand_case

    initial begin
        apb_req = '0;
        presetn = 1'b0;
        seed = 32'hBC1F3547;
        errors = 0;
        n_tests = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, read-only and unmapped places
        apb(1'b0, 8'h00, 32'h0);
        `CHK("ctrl", 32'h0, rd)
        apb(1'b0, 8'h08, 32'h0);
        `CHK("en", 32'hF, rd)
        apb(1'b1, 8'h0C, 32'h7FF);
        apb(1'b0, 8'h0C, 32'h0);
        `CHK("st", {21'h0, exp_st(5'h00, 6'h00, 4'hF)}, rd)
        apb(1'b0, 8'h18, 32'h0);
        `CHK("err", 1'b1, err)
        `CHK("bottom", 1'b1, sq_out.ant_bottom)
        $display("test reset done");
        // surface squitters stopped by format: acquisition starts at once
        apb(1'b1, 8'h04, 32'h0B);
        apb(1'b1, 8'h08, 32'h4);
        apb(1'b1, 8'h00, 32'h10);
        repeat (2 * AP) @(posedge pclk);
        a0 = n_acq;
        apb(1'b1, 8'h00, 32'h12);
        `CHK("none", a0, n_acq)
        repeat (6) @(posedge pclk);
        `CHK("start", a0 + 16'h1, n_acq)
        {a0, e0, t0} = {n_acq, n_es, n_top};
        repeat (5 * AP + AP / 2) @(posedge pclk);
        `CHK("rate", a0 + 16'h5, n_acq)
        `CHK("top5", t0 + 16'h5, n_top)
        `CHK("noes", e0, n_es)
        $display("test format stop done");
        repeat (16) rand_case();
        $display("test random done");
        // mid-run reset clears the control flags
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        `CHK("ctrl2", 32'h0, rd)
        $display("test second reset done");
        summarize();
    end
endmodule : tb_acq_squitter_ctrl
